// ===== cito_consts.svh
// constants for the instruction fetch, decode and timing block
// Summary of operation
// [RL1] single-word instruction is 24 bits, upper 8 bits form the opcode
// [RL2] double-word instructions span two program words, 48 bits in total
// [RL3] second word of a double-word instruction has its top 8 bits zero
// [RL4] second word executed on its own acts as a no-operation
// [RL5] each double-word instruction completes in exactly two cycles
// [RL6] single-word takes one cycle, two when condition true or PC changes
// [RL7] branches, indirect call/jump, table access and returns take two or three cycles
// [RL8] performed skip takes two cycles over one word, three over two words
// [RL9] double-word data move executes in two cycles
// [RL10] no suffix means word, byte suffix byte, double suffix double-word
// [RL11] file-register default register form uses register zero as source and destination
// [RL12] bit position operand is 4 bits selecting one of sixteen bits
// [RL13] 10-bit literal limited to 0..255 in byte mode, 0..1023 in word mode
// [RL14] 23-bit program address literal always has bit zero clear
// [RL15] source, destination, base and divide fields select one of sixteen registers
// [RL16] accumulator operations select exactly one of two accumulators A or B
// [RL17] accumulator write-back targets register 13, direct or post-incremented by 2
// [RL18] square uses one identical register pair among registers 4 to 7
// [RL19] carry, digit carry, negative, overflow, sticky zero; only listed flags change
// [RL20] separate overflow and saturate flags per accumulator, set by accumulator ops
// [RL21] multi-cycle instructions hold fetch so extra cycles are side-effect free
`ifndef CITO_CONSTS_SVH
`define CITO_CONSTS_SVH
// opcodes (upper byte of the instruction word; the BCC and ACC class codes give only its upper nibble)
`define CITO_OP_NOP 8'h00
`define CITO_OP_BRW 8'h01
`define CITO_OP_CALLA 8'h02
`define CITO_OP_GOTOA 8'h04
`define CITO_OP_RET 8'h06
`define CITO_OP_BCC_HI 4'h3
`define CITO_OP_SKIPS 8'hA6
`define CITO_OP_SKIPC 8'hA7
`define CITO_OP_TBLRD 8'hBA
`define CITO_OP_TBLWR 8'hBB
`define CITO_OP_MOVD 8'hBE
`define CITO_OP_ACC_HI 4'hC
`define CITO_OP_SQR 8'hF0
// extra cycles beyond the first
`define CITO_XC_BRANCH 2'h1
`define CITO_XC_TABLE 2'h1
`define CITO_XC_RETURN 2'h2
`define CITO_XC_MOVD 2'h1
`define CITO_XC_TAKEN 2'h1
// condition code meaning unconditional
`define CITO_CC_ALWAYS 4'hF
// operand field positions
`define CITO_F_SRC_LO 0
`define CITO_F_DST_LO 7
`define CITO_F_BASE_LO 11
`define CITO_F_BIT_LO 12
`define CITO_F_LIT_LO 4
`define CITO_F_BYTE 14
`define CITO_F_DEFREG 13
`define CITO_F_ACC 7
`define CITO_F_AWB_LO 5
`define CITO_LIT_BYTE_MAX 10'h0FF
`define CITO_AWB_REG 4'hD
`define CITO_SQR_BASE 4'h4
// register map, byte addresses
`define CITO_ADR_CTRL 8'h00
`define CITO_ADR_FLAGS 8'h04
`define CITO_ADR_ERR 8'h08
`define CITO_ADR_STATE 8'h0C
`define CITO_CTRL_RST 32'h0000_0000
`define CITO_ERR_W2 0
`define CITO_ERR_ODD 1
`define CITO_ERR_LIT 2
`endif

// ===== cito_pkg.sv
// types shared by the instruction fetch, decode and timing block
`default_nettype none
package cito_pkg;
    typedef enum logic [2:0] {S_EXEC, S_WORD2, S_SKIP, S_SKIP2, S_STALL} cito_state_type;
    typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_DWORD} cito_size_type;
    // status flags, mcu group then accumulator group
    typedef struct packed {
        logic c;
        logic digit_carry_flag;
        logic n;
        logic overflow_flag;
        logic z;
        logic acc_a_overflow_flag;
        logic acc_b_overflow_flag;
        logic acc_a_saturate_flag;
        logic acc_b_saturate_flag;
    } cito_flags_type;
    // one decoded instruction handed to the datapath
    typedef struct packed {
        logic [7:0] opcode;
        cito_size_type size;
        logic [3:0] working_register_select;
        logic [3:0] dst_sel;
        logic [3:0] base_register_select;
        logic [3:0] bit_position_field;
        logic [9:0] ten_bit_literal;
        logic default_working_register;
        logic acc_b;
        logic awb_en;
        logic awb_postinc;
        logic pc_load;
        logic two_word;
        logic [22:0] program_address_literal;
    } cito_exec_type;
endpackage : cito_pkg
`default_nettype wire

// ===== cito_core.sv
// instruction fetch sequencer, operand decoder and status flags
`default_nettype none
`include "cito_consts.svh"
module cito_core #(
    parameter int AW = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [23:0] IWORD,
    input wire logic IWORD_VALID,
    input wire logic FLAG_WE,
    input wire cito_pkg::cito_flags_type FLAG_MASK,
    input wire cito_pkg::cito_flags_type FLAG_VAL,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [AW-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic WB_ACK_O,
    output logic [31:0] WB_DAT_O,
    output logic FETCH_EN,
    output logic EXEC_VALID,
    output logic EXEC_NOP,
    output cito_pkg::cito_exec_type EXEC_INSN,
    output cito_pkg::cito_flags_type FLAGS
);
    cito_pkg::cito_state_type st_r, st_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [23:0] first_r;
    logic [2:0] err_r;
    logic run_r;
    logic take;
    logic [7:0] op;
    logic wb_req, ctrl_wr, flags_wr, err_wr;

    // state names, local aliases of the package enum
    localparam cito_pkg::cito_state_type S_EXEC = cito_pkg::S_EXEC;
    localparam cito_pkg::cito_state_type S_WORD2 = cito_pkg::S_WORD2;
    localparam cito_pkg::cito_state_type S_SKIP = cito_pkg::S_SKIP;
    localparam cito_pkg::cito_state_type S_SKIP2 = cito_pkg::S_SKIP2;
    localparam cito_pkg::cito_state_type S_STALL = cito_pkg::S_STALL;

    // word decode helpers
    function automatic logic is_dw(input logic [7:0] o);
        return (o == `CITO_OP_CALLA) || (o == `CITO_OP_GOTOA);
    endfunction : is_dw

    function automatic logic cond_true(input logic [3:0] cc, input cito_pkg::cito_flags_type f);
        logic r;
        r = 1'b0;
        case (cc)
            4'h0: r = f.overflow_flag;
            4'h1: r = f.c;
            4'h2: r = f.z;
            4'h3: r = f.n;
            4'h4: r = !f.overflow_flag;
            4'h5: r = !f.c;
            4'h6: r = !f.z;
            4'h7: r = !f.n;
            4'h8: r = f.acc_a_overflow_flag;
            4'h9: r = f.acc_b_overflow_flag;
            4'hA: r = f.acc_a_saturate_flag;
            4'hB: r = f.acc_b_saturate_flag;
            4'hF: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : cond_true

    // extra cycles run as no-operations after the first
    function automatic logic [1:0] extra(input logic [7:0] o, input cito_pkg::cito_flags_type f);
        logic [1:0] x;
        x = 2'h0;
        if (o == `CITO_OP_BRW) begin
            x = `CITO_XC_BRANCH; // RL7
        end else if (o == `CITO_OP_TBLRD || o == `CITO_OP_TBLWR) begin
            x = `CITO_XC_TABLE; // RL7
        end else if (o == `CITO_OP_RET) begin
            x = `CITO_XC_RETURN; // RL7
        end else if (o == `CITO_OP_MOVD) begin
            x = `CITO_XC_MOVD; // RL9
        end else if (o[7:4] == `CITO_OP_BCC_HI && cond_true(o[3:0], f)) begin
            x = `CITO_XC_TAKEN; // RL6
        end
        return x;
    endfunction : extra

    // operand fields of a single word
    function automatic cito_pkg::cito_exec_type decode(input logic [23:0] w,
                                                       input cito_pkg::cito_flags_type f);
        cito_pkg::cito_exec_type e;
        logic [1:0] sq;
        e = '0;
        sq = w[1:0];
        e.opcode = w[23:16]; // RL1
        e.working_register_select = w[`CITO_F_SRC_LO +: 4]; // RL15
        e.dst_sel = w[`CITO_F_DST_LO +: 4];
        e.base_register_select = w[`CITO_F_BASE_LO +: 4];
        e.bit_position_field = w[`CITO_F_BIT_LO +: 4]; // RL12
        e.size = w[`CITO_F_BYTE] ? cito_pkg::SZ_BYTE : cito_pkg::SZ_WORD; // RL10
        if (e.opcode == `CITO_OP_MOVD) begin
            e.size = cito_pkg::SZ_DWORD; // RL10
        end
        e.ten_bit_literal = w[`CITO_F_LIT_LO +: 10];
        if (e.size == cito_pkg::SZ_BYTE) begin
            e.ten_bit_literal = {2'h0, w[`CITO_F_LIT_LO +: 8]}; // RL13
        end
        e.default_working_register = w[`CITO_F_DEFREG];
        if (e.default_working_register) begin
            e.working_register_select = 4'h0; // RL11
            e.dst_sel = 4'h0; // RL11
        end
        if (e.opcode[7:4] == `CITO_OP_ACC_HI) begin
            e.acc_b = w[`CITO_F_ACC]; // RL16
            e.awb_en = (w[`CITO_F_AWB_LO +: 2] != 2'h0);
            e.awb_postinc = (w[`CITO_F_AWB_LO +: 2] == 2'h2); // RL17
            if (e.awb_en) begin
                e.dst_sel = `CITO_AWB_REG; // RL17
            end
        end
        if (e.opcode == `CITO_OP_SQR) begin
            e.working_register_select = `CITO_SQR_BASE | {2'h0, sq}; // RL18
            e.base_register_select = `CITO_SQR_BASE | {2'h0, sq}; // RL18
            e.default_working_register = 1'b0; // RL11
        end
        e.pc_load = (extra(e.opcode, f) != 2'h0) && (e.opcode != `CITO_OP_TBLRD)
                    && (e.opcode != `CITO_OP_TBLWR) && (e.opcode != `CITO_OP_MOVD);
        return e;
    endfunction : decode

    assign take = FETCH_EN && IWORD_VALID;
    assign op = IWORD[23:16];
    assign wb_req = WB_CYC_I && WB_STB_I;
    assign ctrl_wr = wb_req && WB_WE_I && WB_ACK_O && WB_SEL_I[0] && WB_ADR_I == `CITO_ADR_CTRL;
    assign flags_wr = wb_req && WB_WE_I && WB_ACK_O && WB_ADR_I == `CITO_ADR_FLAGS;
    assign err_wr = wb_req && WB_WE_I && WB_ACK_O && WB_SEL_I[0] && WB_ADR_I == `CITO_ADR_ERR;

    // sequencer next state
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            S_EXEC: begin
                if (take) begin
                    if (is_dw(op)) begin
                        st_nxt = S_WORD2; // RL2
                    end else if ((op == `CITO_OP_SKIPS && FLAGS[IWORD[15:12]]) ||
                                 (op == `CITO_OP_SKIPC && !FLAGS[IWORD[15:12]])) begin
                        st_nxt = S_SKIP; // RL8
                    end else if (extra(op, FLAGS) != 2'h0) begin
                        st_nxt = S_STALL; // RL21
                        cnt_nxt = extra(op, FLAGS) - 2'h1;
                    end
                end
            end
            S_WORD2: begin
                if (take) begin
                    st_nxt = S_EXEC; // RL5
                end
            end
            S_SKIP: begin
                if (take) begin
                    st_nxt = is_dw(op) ? S_SKIP2 : S_EXEC; // RL8
                end
            end
            S_SKIP2: begin
                if (take) begin
                    st_nxt = S_EXEC; // RL8
                end
            end
            default: begin
                if (cnt_r == 2'h0) begin
                    st_nxt = S_EXEC;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
        endcase
    end

    // sequencer state and fetch gate
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r <= S_EXEC;
            cnt_r <= 2'h0;
            FETCH_EN <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            FETCH_EN <= run_r && (st_nxt != S_STALL); // RL21
        end
    end

    // first word of a pair
    always_ff @(posedge CLK) begin
        if (RST) begin
            first_r <= 24'h00_0000;
        end else if (st_r == S_EXEC && take) begin
            first_r <= IWORD;
        end
    end

    // decoded instruction and no-operation pulses
    always_ff @(posedge CLK) begin
        if (RST) begin
            EXEC_VALID <= 1'b0;
            EXEC_NOP <= 1'b0;
            EXEC_INSN <= '0;
        end else begin
            EXEC_VALID <= 1'b0;
            EXEC_NOP <= (st_r == S_STALL) || ((st_r == S_SKIP || st_r == S_SKIP2) && take);
            if (st_r == S_EXEC && take && !is_dw(op)) begin
                EXEC_VALID <= 1'b1; // RL4
                EXEC_INSN <= decode(IWORD, FLAGS);
            end else if (st_r == S_WORD2 && take) begin
                EXEC_VALID <= 1'b1; // RL5
                EXEC_INSN <= decode(first_r, FLAGS);
                EXEC_INSN.two_word <= 1'b1;
                EXEC_INSN.pc_load <= 1'b1;
                EXEC_INSN.program_address_literal <= {IWORD[6:0], first_r[15:1], 1'b0}; // RL14
            end
        end
    end

    // decode error flags, set wins over write-one-to-clear
    always_ff @(posedge CLK) begin
        if (RST) begin
            err_r <= 3'h0;
        end else begin
            err_r <= (err_wr ? err_r & ~WB_DAT_I[2:0] : err_r) | {
                st_r == S_EXEC && take && !is_dw(op) && IWORD[`CITO_F_BYTE] &&
                    IWORD[`CITO_F_LIT_LO +: 10] > `CITO_LIT_BYTE_MAX, // RL13
                st_r == S_WORD2 && take && first_r[0], // RL14
                st_r == S_WORD2 && take && IWORD[23:16] != 8'h00 // RL3
            };
        end
    end

    // status flags: datapath update masked by instruction class, wins over software
    always_ff @(posedge CLK) begin
        if (RST) begin
            FLAGS <= '0;
        end else if (FLAG_WE && EXEC_VALID && EXEC_INSN.opcode != `CITO_OP_NOP) begin // RL4
            if (EXEC_INSN.opcode[7:4] == `CITO_OP_ACC_HI) begin
                if (FLAG_MASK.acc_a_overflow_flag) FLAGS.acc_a_overflow_flag <= FLAG_VAL.acc_a_overflow_flag; // RL20
                if (FLAG_MASK.acc_b_overflow_flag) FLAGS.acc_b_overflow_flag <= FLAG_VAL.acc_b_overflow_flag; // RL20
                if (FLAG_MASK.acc_a_saturate_flag) FLAGS.acc_a_saturate_flag <= FLAG_VAL.acc_a_saturate_flag; // RL20
                if (FLAG_MASK.acc_b_saturate_flag) FLAGS.acc_b_saturate_flag <= FLAG_VAL.acc_b_saturate_flag; // RL20
            end else begin
                if (FLAG_MASK.c) FLAGS.c <= FLAG_VAL.c; // RL19
                if (FLAG_MASK.digit_carry_flag) FLAGS.digit_carry_flag <= FLAG_VAL.digit_carry_flag;
                if (FLAG_MASK.n) FLAGS.n <= FLAG_VAL.n;
                if (FLAG_MASK.overflow_flag) FLAGS.overflow_flag <= FLAG_VAL.overflow_flag;
                if (FLAG_MASK.z) FLAGS.z <= FLAGS.z & FLAG_VAL.z; // RL19
            end
        end else if (flags_wr) begin
            FLAGS <= WB_DAT_I[8:0];
        end
    end

    // control register: run enable
    always_ff @(posedge CLK) begin
        if (RST) begin
            run_r <= 1'(`CITO_CTRL_RST);
        end else if (ctrl_wr) begin
            run_r <= WB_DAT_I[0];
        end
    end

    // wishbone slave: ack one cycle after request, read data with it
    always_ff @(posedge CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req && !WB_ACK_O;
            if (WB_ADR_I == `CITO_ADR_CTRL) begin
                WB_DAT_O <= {31'h0000_0000, run_r};
            end else if (WB_ADR_I == `CITO_ADR_FLAGS) begin
                WB_DAT_O <= {23'h00_0000, FLAGS};
            end else if (WB_ADR_I == `CITO_ADR_ERR) begin
                WB_DAT_O <= {29'h0000_0000, err_r};
            end else if (WB_ADR_I == `CITO_ADR_STATE) begin
                WB_DAT_O <= {19'h0_0000, EXEC_INSN.opcode, cnt_r, st_r};
            end else begin
                WB_DAT_O <= 32'h0000_0000;
            end
        end
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_dw_completes: assert property (st_r == S_WORD2 && take |=> // RL5
        EXEC_VALID && EXEC_INSN.two_word ##1 !EXEC_NOP)
        else $error("double-word did not finish in two cycles");

    a_orphan_nop: assert property (st_r == S_EXEC && take && op == 8'h00 |=> // RL4
        EXEC_VALID && !EXEC_INSN.pc_load ##1 ($stable(FLAGS) || $past(flags_wr)))
        else $error("lone second word not a no-operation");

    a_word2_check: assert property (st_r == S_WORD2 && take && op != 8'h00 |=> err_r[0]) // RL3
        else $error("bad second word not flagged");

    a_return_cycles: assert property (st_r == S_EXEC && take && op == `CITO_OP_RET |=> // RL7
        EXEC_VALID ##1 EXEC_NOP [*2] ##1 !EXEC_NOP)
        else $error("return not three cycles");

    a_branch_cycles: assert property (st_r == S_EXEC && take && op == `CITO_OP_BRW |=> // RL7
        EXEC_VALID && EXEC_INSN.pc_load ##1 EXEC_NOP ##1 !EXEC_NOP)
        else $error("computed branch not two cycles");

    a_plain_single: assert property (st_r == S_EXEC && take && op[7:6] == 2'h1 |=> // RL6
        EXEC_VALID ##1 !EXEC_NOP)
        else $error("plain instruction not one cycle");

    a_skip_fetch: assert property (st_r == S_SKIP && take && !is_dw(op) |=> // RL8
        EXEC_NOP && st_r == S_EXEC)
        else $error("skip over one word wrong");

    a_stall_hold: assert property (st_r == S_STALL |-> !FETCH_EN) // RL21
        else $error("fetch not held while stalling");

    a_addr_even: assert property (EXEC_VALID |-> !EXEC_INSN.program_address_literal[0]) // RL14
        else $error("odd program address");

    a_default_reg: assert property (EXEC_VALID && EXEC_INSN.default_working_register && // RL11
        EXEC_INSN.opcode[7:4] != `CITO_OP_ACC_HI |-> EXEC_INSN.dst_sel == 4'h0 &&
        EXEC_INSN.working_register_select == 4'h0)
        else $error("default register not zero");

    a_square_pair: assert property (EXEC_VALID && EXEC_INSN.opcode == `CITO_OP_SQR |-> // RL18
        EXEC_INSN.working_register_select == EXEC_INSN.base_register_select &&
        EXEC_INSN.working_register_select[3:2] == 2'h1)
        else $error("square pair wrong");

    a_zero_sticky: assert property (FLAGS.z && !$past(FLAGS.z) |-> $past(flags_wr)) // RL19
        else $error("zero flag set by instruction");

    a_byte_literal: assert property (EXEC_VALID && EXEC_INSN.size == cito_pkg::SZ_BYTE |-> // RL13
        EXEC_INSN.ten_bit_literal <= `CITO_LIT_BYTE_MAX)
        else $error("byte literal above 255");

    a_table_cycles: assert property (st_r == S_EXEC && take && // RL7
        (op == `CITO_OP_TBLRD || op == `CITO_OP_TBLWR) |=>
        EXEC_VALID && !EXEC_INSN.pc_load ##1 EXEC_NOP ##1 !EXEC_NOP)
        else $error("table access not two cycles");

    a_taken_cond: assert property (st_r == S_EXEC && take && // RL6
        op[7:4] == `CITO_OP_BCC_HI && cond_true(op[3:0], FLAGS) |=>
        EXEC_VALID && EXEC_INSN.pc_load ##1 EXEC_NOP ##1 !EXEC_NOP)
        else $error("taken branch not two cycles");

    a_skip_two: assert property (st_r == S_SKIP && take && is_dw(op) |=> // RL8
        EXEC_NOP && st_r == S_SKIP2)
        else $error("skip over two words wrong");

    c_dw_exec: cover property (st_r == S_WORD2 && take ##1 EXEC_VALID);
    c_skip_two: cover property (st_r == S_SKIP && take && is_dw(op) ##1 st_r == S_SKIP2);
    c_taken_bcc: cover property (EXEC_VALID && EXEC_INSN.opcode[7:4] == `CITO_OP_BCC_HI
        && EXEC_INSN.pc_load ##1 EXEC_NOP);
    c_acc_flags: cover property (FLAG_WE && EXEC_VALID && EXEC_INSN.acc_b);
endmodule : cito_core
`default_nettype wire

// ===== cito_pmem.sv
// program memory model handing instruction words to the core
`default_nettype none
module cito_pmem (
    input wire logic CLK,
    input wire logic RST,
    input wire logic FETCH_EN,
    input wire logic SLOW,
    output logic [23:0] IWORD,
    output logic IWORD_VALID
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem[$];
    int idx;
    int nxt;
    logic gap_r;

    // queue a word for delivery
    task automatic push(input logic [23:0] w);
        mem.push_back(w);
    endtask : push

    // words in order, each held until taken; idle data toggles so stale values never match
    always @(posedge CLK) begin
        if (RST) begin
            mem.delete();
            idx <= 0;
            gap_r <= 1'b0;
            IWORD_VALID <= 1'b0;
            IWORD <= 24'hA5A5A5;
        end else begin
            nxt = idx + int'(FETCH_EN && IWORD_VALID);
            idx <= nxt;
            gap_r <= SLOW && !gap_r;
            if (IWORD_VALID && !FETCH_EN) begin
                IWORD <= IWORD;
            end else if (nxt < mem.size() && !(SLOW && gap_r)) begin
                IWORD <= mem[nxt];
                IWORD_VALID <= 1'b1;
            end else begin
                IWORD <= ~IWORD;
                IWORD_VALID <= 1'b0;
            end
        end
    end
endmodule : cito_pmem
`default_nettype wire

// ===== cito_core_tb.sv
// self-checking bench for the instruction fetch, decode and timing core
`default_nettype none
module cito_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic flag_we = 1'b0;
    logic slow = 1'b0;
    cito_pkg::cito_flags_type flag_mask = '0;
    cito_pkg::cito_flags_type flag_val = '0;
    cito_pkg::cito_flags_type flags;
    cito_pkg::cito_exec_type insn;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic ack, fetch_en, iword_valid, exec_valid, exec_nop;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [23:0] iword;
    int miscompares = 0;
    int check_count = 0;
    int nv = 0;
    int nn = 0;
    logic [31:0] rng = 32'h0DD5898B;

    always #5 clk = ~clk;

    cito_core #(.AW(8)) dut (.CLK(clk), .RST(rst), .IWORD(iword), .IWORD_VALID(iword_valid),
        .FLAG_WE(flag_we), .FLAG_MASK(flag_mask), .FLAG_VAL(flag_val), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
        .WB_ACK_O(ack), .WB_DAT_O(rdat), .FETCH_EN(fetch_en), .EXEC_VALID(exec_valid),
        .EXEC_NOP(exec_nop), .EXEC_INSN(insn), .FLAGS(flags));
    cito_pmem pm (.CLK(clk), .RST(rst), .FETCH_EN(fetch_en), .SLOW(slow), .IWORD(iword),
        .IWORD_VALID(iword_valid));

    // count executed and no-operation cycles
    always @(posedge clk) begin
        nv <= nv + int'(exec_valid === 1'b1);
        nn <= nn + int'(exec_nop === 1'b1);
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd

    // branch condition from code and flag image {c,dc,n,ov,z,oa,ob,sa,sb}
    function automatic logic cond_true(input logic [3:0] cc, input logic [8:0] f);
        case (cc)
            4'h0: return f[5];
            4'h1: return f[8];
            4'h2: return f[4];
            4'h3: return f[6];
            4'h4: return !f[5];
            4'h5: return !f[8];
            4'h6: return !f[4];
            4'h7: return !f[6];
            4'h8: return f[3];
            4'h9: return f[2];
            4'hA: return f[1];
            4'hB: return f[0];
            4'hF: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : cond_true

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    // feed nw words, wait until consumed and fetch resumes, compare pulse counts
    task automatic run(input int nw, input logic [23:0] w0, input logic [23:0] w1,
                       input logic [23:0] w2, input int ev, input int en, input string what);
        int v0, n0, n;
        v0 = nv;
        n0 = nn;
        n = 0;
        pm.push(w0);
        if (nw > 1) pm.push(w1);
        if (nw > 2) pm.push(w2);
        do begin
            @(posedge clk);
            n++;
        end while (!(pm.idx == pm.mem.size() && fetch_en === 1'b1) && n < 200);
        repeat (2) @(posedge clk);
        if (n >= 200) miscompares++;
        chk({what, " valid"}, nv - v0, ev);
        chk({what, " nop"}, nn - n0, en);
    endtask : run

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // hang guard
    initial begin
        #300000;
        miscompares++;
        print_verdict();
    end

    // main sequence
    initial begin
        logic [31:0] q, f, w;
        logic [3:0] b;
        logic sk;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wb(1'b1, 8'h00, 32'h1, q);
        wb(1'b0, 8'h00, 32'h0, q);
        chk("ctrl", q, 32'h1);
        wb(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", q, 32'h0);
        run(1, 24'h00ABCD, 0, 0, 1, 0, "orphan");
        chk("orphan op", insn.opcode, 8'h00);
        run(1, 24'h010003, 0, 0, 1, 1, "computed");
        run(1, 24'hBA0000, 0, 0, 1, 1, "tbl rd");
        run(1, 24'hBB0000, 0, 0, 1, 1, "tbl wr");
        run(1, 24'h060000, 0, 0, 1, 2, "return");
        run(1, 24'hBE0000, 0, 0, 1, 1, "dmove");
        chk("dmove size", insn.size, cito_pkg::SZ_DWORD);
        run(2, 24'h020010, 24'h000001, 0, 1, 0, "call");
        chk("target", insn.program_address_literal, {7'h01, 15'h0008, 1'b0});
        run(2, 24'h040010, 24'h120001, 0, 1, 0, "goto");
        wb(1'b0, 8'h08, 32'h0, q);
        chk("word2 err", q[0], 1'b1);
        wb(1'b1, 8'h08, 32'h7, q);
        // mcu op touches only mcu flags and cannot set zero; acc op only dsp flags
        wb(1'b1, 8'h04, 32'h0, q);
        flag_mask <= '1;
        flag_val <= '1;
        flag_we <= 1'b1;
        run(1, 24'h00FFFF, 0, 0, 1, 0, "orphan we");
        chk("orphan flags", flags, 32'h0);
        run(1, 24'h500000, 0, 0, 1, 0, "flag mcu");
        chk("flags mcu", flags, 32'h1E0);
        run(1, 24'hC00000, 0, 0, 1, 0, "flag acc");
        chk("flags acc", flags, 32'h1EF);
        flag_we <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            f = rnd() & 32'h1FF;
            w = rnd();
            wb(1'b1, 8'h04, f, q);
            wb(1'b0, 8'h04, 32'h0, q);
            chk("flags rw", q, f);
            sk = cond_true(4'(i), f[8:0]);
            run(1, {4'h3, 4'(i), w[15:0]}, 0, 0, 1, int'(sk), "cond");
        end
        for (int i = 0; i < 18; i++) begin
            f = rnd() & 32'h1FF;
            w = rnd();
            b = 4'(i % 9);
            wb(1'b1, 8'h04, f, q);
            sk = f[b] ^ (i >= 9);
            if (i < 9)
                run(2, {8'hA6, b, w[11:0]}, 24'h000000, 0, sk ? 1 : 2, int'(sk), "skip1");
            else
                run(3, {8'hA7, b, w[11:0]}, 24'h020000, 24'h000000, sk ? 1 : 2, sk ? 2 : 0,
                    "skip2");
        end
        slow <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            w = rnd();
            run(1, {4'hC, w[19:0]}, 0, 0, 1, 0, "acc");
            chk("acc sel", insn.acc_b, w[7]);
            chk("awb en", insn.awb_en, w[6:5] != 2'h0);
            chk("awb inc", insn.awb_postinc, w[6:5] == 2'h2);
            run(1, {8'hF0, w[15:0]}, 0, 0, 1, 0, "sqr");
            chk("sqr src", insn.working_register_select, 4'h4 + w[1:0]);
            chk("sqr base", insn.base_register_select, 4'h4 + w[1:0]);
        end
        for (int i = 0; i < 30; i++) begin
            w = rnd();
            w[23:16] = 8'h50 + 8'(w[23:16] % 80);
            sk = w[14] && w[13:4] > 10'h0FF;
            wb(1'b1, 8'h08, 32'h7, q);
            run(1, w[23:0], 0, 0, 1, 0, "alu");
            chk("src", insn.working_register_select, w[13] ? 4'h0 : w[3:0]);
            chk("dst", insn.dst_sel, w[13] ? 4'h0 : w[10:7]);
            chk("base", insn.base_register_select, w[14:11]);
            chk("bit", insn.bit_position_field, w[15:12]);
            chk("defreg", insn.default_working_register, w[13]);
            chk("size", insn.size, w[14] ? cito_pkg::SZ_BYTE : cito_pkg::SZ_WORD);
            chk("lit", insn.ten_bit_literal, sk ? {2'b0, w[11:4]} : w[13:4]);
            wb(1'b0, 8'h08, 32'h0, q);
            chk("lit err", q[2], sk);
        end
        print_verdict();
    end
endmodule : cito_core_tb
`default_nettype wire
